/* hw/scan_watchdog_pkg.sv */
// Purpose: shared constants and types for the scan watchdog and run-stop supervisor
// Assumes: pclk at 125 MHz, APB with 32-bit data
// Notes: register offsets are byte addresses of aligned words

package scan_watchdog_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [13:0] WD_BASE_MS = 14'h0082;
	localparam logic [13:0] WD_STEP_MS = 14'h0064;
	localparam logic [6:0] BCD_TEN = 7'h0A;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_WD_STATE = 8'h0C;

	// status and mask bit positions
	localparam int EV_WD_TIMEOUT = 0;
	localparam int EV_SEQ_ERROR = 1;
	localparam int EV_RUN_STOP = 2;
	localparam int EV_RESUME = 3;
	localparam int EV_COUNT = 4;

	// control bit positions, mask and control reset values
	localparam int CTL_WD_ENABLE = 0;
	localparam int CTL_FAULT_RELEASE = 1;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic CTL_WD_ENABLE_RESET = 1'b1;

	// wd_state field positions
	localparam int WS_STOP_IND = 16;
	localparam int WS_ERR_FLAG = 17;
	localparam int WS_STATE_LO = 20;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		kind_other,
		kind_load_contact,
		kind_refresh,
		kind_run_stop,
		kind_scan_end
	} instr_kind_t;

	typedef struct packed {
		logic valid;
		instr_kind_t kind;
		logic cond_result;
		logic [15:0] operand0;
		logic [15:0] operand1;
		logic [15:0] operand2;
	} instr_t;

	typedef enum logic [1:0] {
		st_run,
		st_stopped,
		st_wd_fault
	} sup_state_t;

endpackage : scan_watchdog_pkg

/* hw/scan_watchdog_run_stop.sv */
// Purpose: scan watchdog with refresh count and run-stop supervision, APB registers
// Assumes: instruction stream from the sequencer is synchronous to pclk
// Notes: all state frozen while ce is low

`timescale 1ns/1ns

module scan_watchdog_run_stop
	import scan_watchdog_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)
(
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction sequencer
	input wire instr_t instr,
	input wire logic monitor_relay,
	input wire logic err_flag_clear,
	input wire logic stop_ind_clear,
	output logic halt,
	output logic restart,
	output logic wd_error,
	output logic err_flag,
	output logic stop_ind,
	// interrupt
	output logic irq
);

	// ****************************************
	// declarations
	// ****************************************
	sup_state_t state;
	logic [31:0] tick_cnt;
	logic ms_tick;
	logic [13:0] wd_ms;
	logic [13:0] refresh_period;
	logic [6:0] refresh_n;
	logic wd_reload;
	logic [13:0] wd_load_val;
	logic wd_expire;
	logic prev_load;
	logic rs_seq_err;
	logic rs_take;
	logic resume;
	logic [EV_COUNT-1:0] status;
	logic [EV_COUNT-1:0] mask;
	logic [EV_COUNT-1:0] events;
	logic wd_enable;
	logic acc_ok;
	logic wr_en;
	logic rd_setup;
	logic fault_release;
	logic mapped;
	logic in_run;
	logic exec;

	// ****************************************
	// instruction decode
	// ****************************************
	assign in_run = (state == st_run);
	assign exec = ce && instr.valid && in_run;

	// count from the first operand as two bcd digits, other operands unused
	assign refresh_n = 7'(instr.operand0[7:4]) * BCD_TEN + 7'(instr.operand0[3:0]);
	assign refresh_period = WD_BASE_MS + WD_STEP_MS * 14'(refresh_n);

	// reload on a taken refresh or on scan end
	always_comb
	begin
		wd_reload = 1'b0;
		wd_load_val = WD_BASE_MS;
		if (exec && instr.kind == kind_refresh && instr.cond_result)
		begin
			wd_reload = 1'b1;
			wd_load_val = refresh_period;
		end
		else if (exec && instr.kind == kind_scan_end)
		begin
			wd_reload = 1'b1;
			wd_load_val = WD_BASE_MS;
		end
	end

	// run-stop decisions
	assign rs_seq_err = exec && instr.kind == kind_run_stop && !prev_load;
	assign rs_take = exec && instr.kind == kind_run_stop && prev_load && !instr.cond_result;
	assign resume = ce && (state == st_stopped) && monitor_relay;

	// remembers whether the last instruction was a load-contact
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_load <= 1'b0;
		else if (exec)
			prev_load <= (instr.kind == kind_load_contact);
	end

	// ****************************************
	// watchdog timer
	// ****************************************
	// millisecond prescaler, restarted on each reload
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt <= '0;
		else if (ce)
		begin
			if (wd_reload || ms_tick || !in_run)
				tick_cnt <= '0;
			else
				tick_cnt <= tick_cnt + 32'h00000001;
		end
	end

	assign ms_tick = in_run && (tick_cnt == 32'(TICK_CYC - 1));
	assign wd_expire = ce && in_run && wd_enable && ms_tick && !wd_reload && wd_ms <= 14'h0001;

	// remaining milliseconds of the current period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wd_ms <= WD_BASE_MS;
		else if (ce)
		begin
			if (wd_reload || !in_run)
				wd_ms <= wd_reload ? wd_load_val : WD_BASE_MS;
			else if (ms_tick && wd_ms != 14'h0000)
				wd_ms <= wd_ms - 14'h0001;
		end
	end

	// ****************************************
	// supervisor state
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= st_run;
		else if (ce)
		begin
			case (state)
				st_run:
				begin
					if (wd_expire)
						state <= st_wd_fault;
					else if (rs_take)
						state <= st_stopped;
				end
				st_stopped:
				begin
					if (monitor_relay)
						state <= st_run;
				end
				st_wd_fault:
				begin
					if (fault_release)
						state <= st_run;
				end
				default:
					state <= st_run;
			endcase
		end
	end

	// halt and error levels
	assign halt = !in_run;
	assign wd_error = (state == st_wd_fault);

	// cold restart pulse on leaving a halt
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			restart <= 1'b0;
		else if (ce)
			restart <= resume || (fault_release && state == st_wd_fault);
	end

	// sequence error flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_flag <= 1'b0;
		else if (ce)
		begin
			if (rs_seq_err)
				err_flag <= 1'b1;
			else if (err_flag_clear)
				err_flag <= 1'b0;
		end
	end

	// temporary-stop indicator, only the program clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stop_ind <= 1'b0;
		else if (ce)
		begin
			if (resume)
				stop_ind <= 1'b1;
			else if (stop_ind_clear)
				stop_ind <= 1'b0;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	assign rd_setup = psel && !penable && ce;
	assign pready = ce && acc_ok;
	assign wr_en = psel && penable && pready && pwrite;
	assign fault_release = wr_en && paddr == OFS_CONTROL && pwdata[CTL_FAULT_RELEASE];
	assign mapped = paddr == OFS_STATUS || paddr == OFS_MASK ||
		paddr == OFS_CONTROL || paddr == OFS_WD_STATE;

	// access phase readiness, armed by the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_ok <= 1'b0;
		else if (ce)
			acc_ok <= rd_setup;
	end

	// read data and error latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (rd_setup)
		begin
			pslverr <= !mapped;
			case (paddr)
				OFS_STATUS: prdata <= 32'(status);
				OFS_MASK: prdata <= 32'(mask);
				OFS_CONTROL: prdata <= 32'(wd_enable);
				OFS_WD_STATE:
				begin
					prdata <= 32'(wd_ms);
					prdata[WS_STOP_IND] <= stop_ind;
					prdata[WS_ERR_FLAG] <= err_flag;
					prdata[WS_STATE_LO +: 2] <= state;
				end
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// mask and control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask <= MASK_RESET;
			wd_enable <= CTL_WD_ENABLE_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == OFS_MASK)
				mask <= pwdata[EV_COUNT-1:0];
			if (paddr == OFS_CONTROL)
				wd_enable <= pwdata[CTL_WD_ENABLE];
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign events[EV_WD_TIMEOUT] = wd_expire;
	assign events[EV_SEQ_ERROR] = rs_seq_err;
	assign events[EV_RUN_STOP] = rs_take;
	assign events[EV_RESUME] = resume;

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status <= '0;
		else if (ce)
		begin
			if (wr_en && paddr == OFS_STATUS)
				status <= (status & ~pwdata[EV_COUNT-1:0]) | events;
			else
				status <= status | events;
		end
	end

	assign irq = |(status & mask);

	// ****************************************
	// assertions
	// ****************************************
	sequence s_refresh_taken;
		exec && instr.kind == kind_refresh && instr.cond_result;
	endsequence

	sequence s_run_stop_ok;
		exec && instr.kind == kind_run_stop && prev_load;
	endsequence

	sequence s_resume;
		ce && state == st_stopped && monitor_relay;
	endsequence

	refresh_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_refresh_taken |=> wd_ms == WD_BASE_MS + WD_STEP_MS * 14'($past(refresh_n)))
		else $error("refresh did not load its period");

	refresh_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		exec && instr.kind == kind_refresh && !instr.cond_result && !ms_tick
		|=> wd_ms == $past(wd_ms))
		else $error("refresh with condition 0 changed the timer");

	period_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_refresh_taken |-> wd_load_val >= WD_BASE_MS && wd_load_val <= 14'h2730)
		else $error("refresh period out of range");

	default_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		exec && instr.kind == kind_scan_end |=> wd_ms == WD_BASE_MS)
		else $error("scan end did not load default period");

	timeout_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		wd_expire |=> wd_error && halt && status[EV_WD_TIMEOUT])
		else $error("timeout did not halt");

	seq_error_a: assert property (@(posedge pclk) disable iff (!presetn)
		rs_seq_err |=> err_flag && state != st_stopped)
		else $error("misplaced run-stop not flagged");

	run_stop_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_run_stop_ok ##0 instr.cond_result ##0 !wd_expire |=> state == st_run)
		else $error("run-stop with condition 1 halted");

	run_stop_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_run_stop_ok ##0 !instr.cond_result ##0 !wd_expire |=> halt && state == st_stopped)
		else $error("run-stop did not halt");

	resume_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_resume |=> restart && stop_ind && !halt ##1 !restart)
		else $error("resume did not restart once and set indicator");

	indicator_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		stop_ind && !stop_ind_clear |=> stop_ind)
		else $error("indicator cleared without program");

endmodule : scan_watchdog_run_stop

/* verif/sequencer_model.sv */
// Purpose: program-side model driving instructions, relay and flag clears
// Assumes: signals change just after a rising pclk
// Notes: unused operand words carry random noise
`timescale 1ns/1ns
module sequencer_model
	import scan_watchdog_pkg::*;
(
	// clock
	input wire logic pclk,
	// program side
	output instr_t instr,
	output logic monitor_relay,
	output logic err_flag_clear,
	output logic stop_ind_clear
);
	// ****************************************
	// program actions
	// ****************************************
	// quiet at time zero
	initial
	begin
		instr = '0;
		monitor_relay = 1'b0;
		err_flag_clear = 1'b0;
		stop_ind_clear = 1'b0;
	end
	// one instruction, count as two bcd digits
	task automatic issue(input instr_kind_t k, input logic c, input logic [15:0] op0);
		@(posedge pclk);
		instr <= '{1'b1, k, c, op0, 16'($urandom), 16'($urandom)};
	endtask : issue
	task automatic idle();
		@(posedge pclk);
		instr.valid <= 1'b0;
	endtask : idle
	task automatic set_relay(input logic v);
		@(posedge pclk);
		monitor_relay <= v;
	endtask : set_relay
	// program clears both sticky flags itself
	task automatic clear_flags();
		@(posedge pclk);
		err_flag_clear <= 1'b1;
		stop_ind_clear <= 1'b1;
		@(posedge pclk);
		err_flag_clear <= 1'b0;
		stop_ind_clear <= 1'b0;
	endtask : clear_flags
endmodule : sequencer_model

/* verif/scan_watchdog_run_stop_bench.sv */
// Purpose: self-checking bench for the scan watchdog and run-stop supervisor
// Assumes: short tick so a 130 ms period is 2600 cycles
// Notes: ce stays high, apb transfers wait on pready
`timescale 1ns/1ns
module scan_watchdog_run_stop_bench
	import scan_watchdog_pkg::*;
;
	// ****************************************
	// signals, model and tasks
	// ****************************************
	localparam int TC = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, halt, restart, wd_error, err_flag, stop_ind, irq;
	instr_t instr;
	logic monitor_relay, err_flag_clear, stop_ind_clear;
	int miscompares = 0;
	int samples_checked = 0;
	int model_status = 0;
	int ms_q[$];
	logic [31:0] rd;
	logic er;
	int n;
	// free-running clock
	always #4 pclk = ~pclk;
	scan_watchdog_run_stop #(.TICK_CYC(TC)) scan_watchdog_run_stop_i (.pclk(pclk),
		.presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr(instr), .monitor_relay(monitor_relay),
		.err_flag_clear(err_flag_clear), .stop_ind_clear(stop_ind_clear), .halt(halt),
		.restart(restart), .wd_error(wd_error), .err_flag(err_flag),
		.stop_ind(stop_ind), .irq(irq));
	sequencer_model sequencer_model_i (.pclk(pclk), .instr(instr),
		.monitor_relay(monitor_relay), .err_flag_clear(err_flag_clear),
		.stop_ind_clear(stop_ind_clear));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// one apb transfer, held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			miscompares++;
			print_verdict();
		end
		// answer taken at the same edge that saw pready, then released
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic read_ms();
		apb(1'b0, OFS_WD_STATE, 32'h0);
		check("wd_ms", rd & 32'h3FFF, ms_q[$]);
	endtask : read_ms
	// restart is a single-cycle pulse
	task automatic wait_restart();
		int k;
		#1;
		for (k = 0; k < 20 && restart !== 1'b1; k++)
		begin
			@(posedge pclk);
			#1;
		end
		check("restart", restart, 1'b1);
		@(posedge pclk);
		#1;
		check("restart end", restart, 1'b0);
	endtask : wait_restart
	// main sequence
	initial
	begin
		void'($urandom(32'hA5ED));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		ms_q.push_back(130);
		sequencer_model_i.issue(kind_refresh, 1'b0, 16'h0009);
		sequencer_model_i.idle();
		read_ms();
		apb(1'b0, OFS_MASK, 32'h0);
		check("mask", rd, 32'h0);
		apb(1'b0, OFS_CONTROL, 32'h0);
		check("control", rd, 32'h1);
		n = $urandom_range(99);
		sequencer_model_i.issue(kind_refresh, 1'b1, 16'h0012);
		sequencer_model_i.issue(kind_refresh, 1'b1, 16'((n / 10) * 16 + n % 10));
		sequencer_model_i.idle();
		ms_q.push_back(130 + 100 * n);
		read_ms();
		sequencer_model_i.issue(kind_scan_end, 1'b1, 16'h0);
		sequencer_model_i.idle();
		ms_q.push_back(130);
		read_ms();
		sequencer_model_i.issue(kind_load_contact, 1'b1, 16'h0);
		sequencer_model_i.issue(kind_run_stop, 1'b0, 16'h0);
		sequencer_model_i.idle();
		#1 check("halt", halt, 1'b1);
		model_status |= 4;
		sequencer_model_i.issue(kind_refresh, 1'b1, 16'h0005);
		sequencer_model_i.idle();
		ms_q.push_back(130);
		read_ms();
		sequencer_model_i.set_relay(1'b1);
		wait_restart();
		model_status |= 8;
		check("halt", halt, 1'b0);
		repeat (5) @(posedge pclk);
		check("stop_ind", stop_ind, 1'b1);
		sequencer_model_i.clear_flags();
		#1 check("stop_ind", stop_ind, 1'b0);
		sequencer_model_i.issue(kind_load_contact, 1'b1, 16'h0);
		sequencer_model_i.issue(kind_run_stop, 1'b1, 16'h0);
		sequencer_model_i.idle();
		#1 check("halt", {halt, err_flag}, 2'b00);
		sequencer_model_i.issue(kind_other, 1'b1, 16'h0);
		sequencer_model_i.issue(kind_run_stop, 1'b0, 16'h0);
		sequencer_model_i.idle();
		#1 check("err_flag", {halt, err_flag}, 2'b01);
		model_status |= 2;
		sequencer_model_i.clear_flags();
		#1 check("err_flag", err_flag, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status", rd, model_status);
		check("irq", irq, 1'b0);
		apb(1'b1, OFS_MASK, 32'h4);
		#1 check("irq", irq, 1'b1);
		apb(1'b1, OFS_STATUS, 32'hF);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status", rd, 32'h0);
		check("irq", irq, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped err", er, 1'b1);
		check("unmapped data", rd, 32'h0);
		sequencer_model_i.issue(kind_refresh, 1'b1, 16'h0000);
		sequencer_model_i.idle();
		n = 0;
		while (wd_error !== 1'b1 && n < 3000)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (wd_error !== 1'b1)
		begin
			miscompares++;
			print_verdict();
		end
		check("wd window", n >= 129 * TC - 2 && n <= 130 * TC + 2, 1'b1);
		check("halt", halt, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status", rd, 32'h1);
		apb(1'b1, OFS_CONTROL, 32'h3);
		wait_restart();
		check("wd_error", {halt, wd_error}, 2'b00);
		// mid-run reset brings back the power-up state
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		#1 check("reset outs", {halt, wd_error, err_flag, stop_ind, restart, irq}, 6'h00);
		apb(1'b0, OFS_WD_STATE, 32'h0);
		check("reset wd_state", rd, 130);
		apb(1'b0, OFS_MASK, 32'h0);
		check("reset mask", rd, 32'h0);
		print_verdict();
	end
endmodule : scan_watchdog_run_stop_bench
